// ===== rtl/tmr_slave_ctrl.sv
// timer slave-mode controller, event flags and event generation
//
// Chosen here: the address-and-strobe port.
`include "tmr_defs.svh"
`default_nettype none
module tmr_slave_ctrl
   import tmr_pkg::*;
#(
   parameter bit HAS_TRIG_CTRL = 1'b1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // internal trigger lines from other timers
   input wire logic internal_trigger_0_i,
   input wire logic internal_trigger_1_i,
   // channel capture pins
   input wire logic [2:0] chan_capture_in_i,
   // towards other timers and the interrupt controller
   output logic trigger_out_o,
   output logic [4:0] irq_req_o,
   output logic [15:0] count_o
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tmr_state_type st_q;
   tmr_state_type st_d;
   tmr_req_type req;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                  wr: reg_wr_i, rd: reg_rd_i};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic trig_sel;
      logic trig_now;
      logic trig_eff;
      logic trig_rise;
      logic trig_fall;
      logic ctrl_on;
      logic run_en;
      logic count_in;
      logic tick;
      logic ovf;
      logic upd_evt;
      logic upd_flag;
      logic cnt_reset;
      logic [15:0] psc_lim;
      logic [15:0] cnt_nx;
      logic [7:0] egr;
      logic [7:0] clr1;
      logic [7:0] clr2;
      logic [7:0] set1;
      logic [7:0] set2;
      logic [2:0] cap_edge;
      logic cap;
      logic is_out;
      tmr_smode_type sm;

      st_d = st_q;
      trig_sel = 1'b0;
      set1 = `TMR_RST_BYTE;
      set2 = `TMR_RST_BYTE;
      clr1 = `TMR_RST_BYTE;
      clr2 = `TMR_RST_BYTE;
      egr = `TMR_RST_BYTE;
      cap = 1'b0;
      is_out = 1'b0;
      cnt_nx = st_q.cnt;
      trig_now = 1'b0;
      trig_eff = 1'b0;
      trig_rise = 1'b0;
      trig_fall = 1'b0;
      ctrl_on = 1'b0;
      run_en = 1'b0;
      count_in = 1'b0;
      tick = 1'b0;
      ovf = 1'b0;
      upd_evt = 1'b0;
      upd_flag = 1'b0;
      cnt_reset = 1'b0;
      psc_lim = `TMR_RST_WORD;
      cap_edge = 3'h0;
      sm = tmr_smode_type'(st_q.smcr[`TMR_SMCR_MODE_HI:`TMR_SMCR_MODE_LO]);

      if (st_q.smcr[`TMR_SMCR_TSEL_HI:`TMR_SMCR_TSEL_LO] ==
          `TMR_TSEL_LINE0) begin
         trig_sel = internal_trigger_0_i;
      end else if (st_q.smcr[`TMR_SMCR_TSEL_HI:`TMR_SMCR_TSEL_LO] ==
                   `TMR_TSEL_LINE1) begin
         trig_sel = internal_trigger_1_i;
      end
      trig_now = trig_sel ^ st_q.ctrl[`TMR_CTRL_POL];
      // one extra stage matches the master's output delay
      trig_eff = st_q.smcr[`TMR_SMCR_DELAY] ? st_q.trig_dly : trig_now;
      trig_rise = trig_eff & ~st_q.trig_prev;
      trig_fall = ~trig_eff & st_q.trig_prev;
      st_d.trig_dly = trig_now;
      st_d.trig_prev = trig_eff;

      // controller absent, reserved codes do nothing
      ctrl_on = HAS_TRIG_CTRL && sm[2];

      // trigger mode sets the enable, never clears it
      if (ctrl_on && sm == TMR_SM_TRIG && trig_rise) begin
         st_d.ctrl[`TMR_CTRL_RUN] = 1'b1;
      end
      run_en = st_q.ctrl[`TMR_CTRL_RUN];

      count_in = 1'b0;
      if (run_en) begin
         if (ctrl_on && sm == TMR_SM_GATED) begin
            // gated by trigger level, no reset on stop
            count_in = trig_eff;
         end else if (ctrl_on && sm == TMR_SM_EXTCLK) begin
            // one prescaler input per rising trigger
            count_in = trig_rise;
         end else begin
            count_in = 1'b1;
         end
      end

      // prescaler, divide by two to the power of psc
      psc_lim = (`TMR_CNT_ONE << st_q.psc) - `TMR_CNT_ONE;
      tick = 1'b0;
      if (count_in) begin
         if (st_q.psc_cnt >= psc_lim) begin
            st_d.psc_cnt = `TMR_RST_WORD;
            tick = 1'b1;
         end else begin
            st_d.psc_cnt = st_q.psc_cnt + `TMR_CNT_ONE;
         end
      end
      ovf = tick && (st_q.cnt == `TMR_CNT_MAX);
      if (tick) begin
         cnt_nx = st_q.cnt + `TMR_CNT_ONE;
      end

      // register writes
      if (req.wr) begin
         if (req.addr == `TMR_OFF_CTRL) begin
            st_d.ctrl = req.wdata & `TMR_CTRL_MASK;
         end else if (req.addr == `TMR_OFF_SMCR) begin
            st_d.smcr = req.wdata & `TMR_SMCR_MASK;
         end else if (req.addr == `TMR_OFF_IER) begin
            st_d.ier = req.wdata & `TMR_IER_MASK;
         end else if (req.addr == `TMR_OFF_SR1) begin
            clr1 = ~req.wdata & `TMR_SR1_MASK;
         end else if (req.addr == `TMR_OFF_SR2) begin
            clr2 = ~req.wdata & `TMR_SR2_MASK;
         end else if (req.addr == `TMR_OFF_EGR) begin
            egr = req.wdata & `TMR_SR1_MASK;
         end else if (req.addr >= `TMR_OFF_CCMR1 &&
                      req.addr <= `TMR_OFF_CCMR3) begin
            st_d.ccmr[2'(req.addr - `TMR_OFF_CCMR1)] = req.wdata;
         end else if (req.addr == `TMR_OFF_CNT_H) begin
            cnt_nx = {req.wdata, st_q.cnt[7:0]};
         end else if (req.addr == `TMR_OFF_CNT_L) begin
            cnt_nx = {st_q.cnt[15:8], req.wdata};
         end else if (req.addr == `TMR_OFF_PSC) begin
            st_d.psc = req.wdata[3:0];
         end else begin
            for (int i = 0; i < `TMR_NUM_CH; i++) begin
               if (req.addr == `TMR_OFF_CCR_BASE + 8'(2 * i)) begin
                  st_d.ccr[i][15:8] = req.wdata;
               end else if (req.addr ==
                            `TMR_OFF_CCR_BASE + 8'(2 * i + 1)) begin
                  st_d.ccr[i][7:0] = req.wdata;
               end
            end
         end
      end
      if (!HAS_TRIG_CTRL) begin
         st_d.ier[`TMR_BIT_TRG] = 1'b0;
         egr[`TMR_BIT_TRG] = 1'b0;
      end

      cnt_reset = ctrl_on && sm == TMR_SM_RESET && trig_rise;
      // software update clears counter and prescaler
      if (egr[`TMR_BIT_UPD] || cnt_reset) begin
         cnt_nx = `TMR_RST_WORD;
         st_d.psc_cnt = `TMR_RST_WORD;
      end
      upd_evt = !st_q.ctrl[`TMR_CTRL_UPD_OFF] &&
                (ovf || egr[`TMR_BIT_UPD] || cnt_reset);
      upd_flag = !st_q.ctrl[`TMR_CTRL_UPD_OFF] &&
                 (ovf || ((egr[`TMR_BIT_UPD] || cnt_reset) &&
                  !st_q.ctrl[`TMR_CTRL_UPD_SRC]));
      set1[`TMR_BIT_UPD] = upd_flag;
      st_d.trig_out = upd_evt;
      st_d.cnt = cnt_nx;

      // trigger flag, both edges when gated
      set1[`TMR_BIT_TRG] = (ctrl_on && (trig_rise ||
                            (sm == TMR_SM_GATED && trig_fall))) ||
                           egr[`TMR_BIT_TRG];

      // capture pins pass two flops before use
      st_d.cap_s1 = chan_capture_in_i;
      st_d.cap_s2 = st_q.cap_s1;
      st_d.cap_prev = st_q.cap_s2;
      cap_edge = st_q.cap_s2 & ~st_q.cap_prev;

      for (int i = 0; i < `TMR_NUM_CH; i++) begin
         is_out = st_q.ccmr[i][`TMR_DIR_HI:`TMR_DIR_LO] == `TMR_DIR_OUT;
         if (is_out) begin
            // generate on output sets flag only
            set1[`TMR_BIT_CH0 + i] = (tick && cnt_nx == st_q.ccr[i]) ||
                                     egr[`TMR_BIT_CH0 + i];
         end else begin
            cap = cap_edge[i] || egr[`TMR_BIT_CH0 + i];
            if (cap) begin
               st_d.ccr[i] = st_q.cnt;
            end
            set1[`TMR_BIT_CH0 + i] = cap;
            set2[`TMR_BIT_CH0 + i] = cap && st_q.sr1[`TMR_BIT_CH0 + i];
            // low byte read clears the flag
            if (req.rd && req.addr == `TMR_OFF_CCR_BASE + 8'(2 * i + 1)) begin
               clr1[`TMR_BIT_CH0 + i] = 1'b1;
            end
         end
      end

      // written zeros clear, capture-channel low byte reads clear sr1 only; set beats clear
      st_d.sr1 = ((st_q.sr1 & ~clr1) | set1) & `TMR_SR1_MASK;
      st_d.sr2 = ((st_q.sr2 & ~clr2) | set2) & `TMR_SR2_MASK;

      // read data, valid only the cycle after the strobe
      st_d.rdata = `TMR_RST_BYTE;
      if (req.rd) begin
         if (req.addr == `TMR_OFF_CTRL) begin
            st_d.rdata = st_q.ctrl;
         end else if (req.addr == `TMR_OFF_SMCR) begin
            st_d.rdata = st_q.smcr;
         end else if (req.addr == `TMR_OFF_IER) begin
            st_d.rdata = st_q.ier;
         end else if (req.addr == `TMR_OFF_SR1) begin
            st_d.rdata = st_q.sr1;
         end else if (req.addr == `TMR_OFF_SR2) begin
            st_d.rdata = st_q.sr2;
         end else if (req.addr >= `TMR_OFF_CCMR1 &&
                      req.addr <= `TMR_OFF_CCMR3) begin
            st_d.rdata = st_q.ccmr[2'(req.addr - `TMR_OFF_CCMR1)];
         end else if (req.addr == `TMR_OFF_CNT_H) begin
            st_d.rdata = st_q.cnt[15:8];
         end else if (req.addr == `TMR_OFF_CNT_L) begin
            st_d.rdata = st_q.cnt[7:0];
         end else if (req.addr == `TMR_OFF_PSC) begin
            st_d.rdata = {4'h0, st_q.psc};
         end else begin
            for (int i = 0; i < `TMR_NUM_CH; i++) begin
               if (req.addr == `TMR_OFF_CCR_BASE + 8'(2 * i)) begin
                  st_d.rdata = st_q.ccr[i][15:8];
               end else if (req.addr ==
                            `TMR_OFF_CCR_BASE + 8'(2 * i + 1)) begin
                  st_d.rdata = st_q.ccr[i][7:0];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = st_q.rdata;
   assign trigger_out_o = st_q.trig_out;
   assign count_o = st_q.cnt;
   assign irq_req_o = {st_q.sr1[`TMR_BIT_TRG] & st_q.ier[`TMR_BIT_TRG],
                       st_q.sr1[3:0] & st_q.ier[3:0]};

endmodule
`default_nettype wire

// ===== include/tmr_defs.svh
// register offsets, field positions and reset values of the timer control
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_SMCR 8'h02
`define TMR_OFF_IER 8'h03
`define TMR_OFF_SR1 8'h04
`define TMR_OFF_SR2 8'h05
`define TMR_OFF_EGR 8'h06
`define TMR_OFF_CCMR1 8'h07
`define TMR_OFF_CCMR2 8'h08
`define TMR_OFF_CCMR3 8'h09
`define TMR_OFF_CNT_H 8'h0a
`define TMR_OFF_CNT_L 8'h0b
`define TMR_OFF_PSC 8'h0c
`define TMR_OFF_CCR_BASE 8'h0d

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMR_CTRL_RUN 0
`define TMR_CTRL_UPD_OFF 1
`define TMR_CTRL_UPD_SRC 2
`define TMR_CTRL_POL 3
`define TMR_SMCR_DELAY 7
`define TMR_SMCR_TSEL_HI 6
`define TMR_SMCR_TSEL_LO 4
`define TMR_SMCR_MODE_HI 2
`define TMR_SMCR_MODE_LO 0
`define TMR_BIT_UPD 0
`define TMR_BIT_TRG 6
`define TMR_BIT_CH0 1
`define TMR_DIR_HI 1
`define TMR_DIR_LO 0

// ----------------------------------------------------------------
// masks, codes and reset values
// ----------------------------------------------------------------
`define TMR_IER_MASK 8'h4f
`define TMR_SR1_MASK 8'h4f
`define TMR_SR2_MASK 8'h0e
`define TMR_CTRL_MASK 8'h0f
`define TMR_SMCR_MASK 8'hf7
`define TMR_PSC_MASK 8'h0f
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_CNT_MAX 16'hffff
`define TMR_CNT_ONE 16'h0001
`define TMR_DIR_OUT 2'b00
`define TMR_TSEL_LINE0 3'b000
`define TMR_TSEL_LINE1 3'b001
`define TMR_NUM_CH 3

`endif

// ===== include/tmr_pkg.sv
// types shared by the timer slave-mode and event-flag logic
`default_nettype none
package tmr_pkg;

   // ----------------------------------------------------------------
   // slave mode codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TMR_SM_OFF = 3'b000,
      TMR_SM_RES1 = 3'b001,
      TMR_SM_RES2 = 3'b010,
      TMR_SM_RES3 = 3'b011,
      TMR_SM_RESET = 3'b100,
      TMR_SM_GATED = 3'b101,
      TMR_SM_TRIG = 3'b110,
      TMR_SM_EXTCLK = 3'b111
   } tmr_smode_type;

   // ----------------------------------------------------------------
   // register port request and whole-block state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmr_req_type;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] smcr;
      logic [7:0] ier;
      logic [7:0] sr1;
      logic [7:0] sr2;
      logic [2:0][7:0] ccmr;
      logic [3:0] psc;
      logic [15:0] psc_cnt;
      logic [15:0] cnt;
      logic [2:0][15:0] ccr;
      logic trig_dly;
      logic trig_prev;
      logic [2:0] cap_s1;
      logic [2:0] cap_s2;
      logic [2:0] cap_prev;
      logic [7:0] rdata;
      logic trig_out;
   } tmr_state_type;

endpackage
`default_nettype wire

// ===== verification/tmr_trig_src.sv
// model of the neighbouring timers driving the trigger lines
`default_nettype none
module tmr_trig_src (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // bench command: lines to raise, cycles high
   input wire logic [1:0] fire_i,
   input wire logic [3:0] len_i,
   // internal trigger lines
   output logic [1:0] trig_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0][3:0] left_q;
   // ----
   // pulse timers
   // ----
   // lines are plain logic outputs, so they fall back low
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      for (int i = 0; i < 2; i++) begin
         if (!arst_n_i) begin
            left_q[i] <= 4'h0;
         end else if (fire_i[i]) begin
            left_q[i] <= len_i;
         end else if (left_q[i] != 4'h0) begin
            left_q[i] <= left_q[i] - 4'h1;
         end
      end
   end
   assign trig_o[0] = left_q[0] != 4'h0;
   assign trig_o[1] = left_q[1] != 4'h0;
endmodule
`default_nettype wire

// ===== verification/tmr_slave_ctrl_chk.sv
// port assertions of the timer slave-mode control
`default_nettype none
module tmr_slave_ctrl_chk #(
   parameter bit HAS_TRIG_CTRL = 1'b1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // trigger lines and results
   input wire logic internal_trigger_0_i,
   input wire logic internal_trigger_1_i,
   input wire logic [4:0] irq_req_o,
   input wire logic [15:0] count_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] ctrl_q;
   logic [7:0] smcr_q;
   logic [7:0] ier_q;
   logic trg;
   // ----
   // shadow of software settings
   // ----
   // misses the enable set by trigger mode: checks avoid that case
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= 8'h00;
         smcr_q <= 8'h00;
         ier_q <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == 8'h00) ctrl_q <= reg_wdata_i;
         if (reg_addr_i == 8'h02) smcr_q <= reg_wdata_i;
         if (reg_addr_i == 8'h03) ier_q <= reg_wdata_i;
      end
   end
   assign trg = (smcr_q[4] ? internal_trigger_1_i : internal_trigger_0_i)
      ^ ctrl_q[3];
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // ----
   // properties
   // ----
   property p_sr2_rsv;
      reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o[0] == 1'b0;
   endproperty
   a_sr2_rsv: assert property (p_sr2_rsv)
      else $error("status two bit 0 set");
   property p_ier_off;
      reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i == 8'h00
         |-> ##2 irq_req_o == 5'h00;
   endproperty
   a_ier_off: assert property (p_ier_off)
      else $error("request without enable");
   property p_ug_clr;
      reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[0]
         |-> ##[1:2] count_o == 16'h0000;
   endproperty
   a_ug_clr: assert property (p_ug_clr)
      else $error("update generate kept counter");
   property p_cen_hold;
      !ctrl_q[0] && (!smcr_q[2] || smcr_q[0]) && !reg_wr_i
         && !$past(reg_wr_i) |=> $stable(count_o);
   endproperty
   a_cen_hold: assert property (p_cen_hold)
      else $error("counter moved while disabled");
   property p_tg_irq;
      reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[6] && ier_q[6]
         && HAS_TRIG_CTRL |-> ##[1:3] irq_req_o[4];
   endproperty
   a_tg_irq: assert property (p_tg_irq)
      else $error("trigger generate gave no request");
   property p_ug_uif;
      reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[0] && ier_q[0]
         && ctrl_q[2:1] == 2'b00 |-> ##[1:3] irq_req_o[0];
   endproperty
   a_ug_uif: assert property (p_ug_uif)
      else $error("update generate gave no request");
   property p_trig_rst;
      HAS_TRIG_CTRL && smcr_q[7:5] == 3'b000 && smcr_q[2:0] == 3'b100
         && $rose(trg) && !reg_wr_i |-> ##[1:3] count_o == 16'h0000;
   endproperty
   a_trig_rst: assert property (p_trig_rst)
      else $error("trigger edge kept counter");
   property p_gate_hold;
      HAS_TRIG_CTRL && smcr_q[7:5] == 3'b000 && smcr_q[2:0] == 3'b101
         && !trg && !$past(trg) && !$past(trg, 2) && !reg_wr_i
         && !$past(reg_wr_i) |=> $stable(count_o);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("counter moved with gate low");
   c_trig_rst: cover property (smcr_q[2:0] == 3'b100 && $rose(trg));
   c_gated: cover property (smcr_q[2:0] == 3'b101 && trg);
   c_extclk: cover property (smcr_q[2:0] == 3'b111 && $rose(trg));
endmodule
bind tmr_slave_ctrl tmr_slave_ctrl_chk #(
   .HAS_TRIG_CTRL(HAS_TRIG_CTRL)
) u_chk (
   .core_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .internal_trigger_0_i,
   .internal_trigger_1_i, .irq_req_o, .count_o
);
`default_nettype wire

// ===== verification/timer_slave_mode_event_flags_tb.sv
// self-checking bench of the timer slave-mode control
`default_nettype none
module timer_slave_mode_event_flags_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, wr, rd, tout;
   logic [7:0] addr, wdata, rdata, m;
   logic [2:0] cap;
   logic [1:0] fire, itr;
   logic [3:0] len;
   logic [4:0] irq, irq2;
   logic [15:0] cnt, c0;
   int num_errors, compares, cyc, n;
   always #20 clk = ~clk;
   tmr_trig_src u_src (.core_clk_i(clk), .arst_n_i(rst_n),
      .fire_i(fire), .len_i(len), .trig_o(itr));
   tmr_slave_ctrl u_dut (.core_clk_i(clk), .arst_n_i(rst_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata),
      .internal_trigger_0_i(itr[0]), .internal_trigger_1_i(itr[1]),
      .chan_capture_in_i(cap), .trigger_out_o(tout), .irq_req_o(irq),
      .count_o(cnt));
   // variant without trigger controller
   tmr_slave_ctrl #(.HAS_TRIG_CTRL(1'b0)) u_dut_nt (.core_clk_i(clk),
      .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(),
      .internal_trigger_0_i(itr[0]), .internal_trigger_1_i(itr[1]),
      .chan_capture_in_i(cap), .trigger_out_o(), .irq_req_o(irq2),
      .count_o());
   // ----
   // tasks
   // ----
   task automatic print_verdict;
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
   endtask
   task automatic irq_chk(input logic [4:0] e);
      repeat (3) @(posedge clk);
      #1;
      chk("irq", {11'h000, irq}, {11'h000, e});
   endtask
   // one pulse, then a gap so edges never merge
   task automatic pulse(input logic [1:0] lines, input logic [3:0] l);
      @(posedge clk);
      fire <= lines;
      len <= l;
      @(posedge clk);
      fire <= 2'b00;
      repeat (int'(l) + 3) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ----
   // main sequence
   // ----
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {addr, wdata, wr, rd, cap, fire, len} = '0;
      n = $urandom(32'h9a7b661c);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 1; a < 10; a++) begin
         rd_chk(8'(a), 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         n = $urandom;
         wr_reg(8'h03, 8'(n));
         rd_chk(8'h03, 8'(n) & 8'h4f);
         wr_reg(8'h07 + 8'(i % 3), 8'(n));
         rd_chk(8'h07 + 8'(i % 3), 8'(n));
         wr_reg(8'h01, 8'(n));
         rd_chk(8'h01, 8'h00);
      end
      wr_reg(8'h02, 8'h90);
      rd_chk(8'h02, 8'h90);
      wr_reg(8'h03, 8'h4f);
      wr_reg(8'h00, 8'h04);
      wr_reg(8'h06, 8'h01);
      rd_chk(8'h04, 8'h00);
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h06, 8'h41);
      rd_chk(8'h04, 8'h41);
      irq_chk(5'h11);
      chk("irq no trigger", {11'h000, irq2}, 16'h0001);
      wr_reg(8'h04, 8'hfe);
      rd_chk(8'h04, 8'h40);
      wr_reg(8'h04, 8'h00);
      for (int ch = 0; ch < 3; ch++) begin
         m = 8'h02 << ch;
         n = $urandom;
         wr_reg(8'h07 + 8'(ch), 8'h00);
         wr_reg(8'h06, m);
         rd_chk(8'h04, m);
         wr_reg(8'h04, 8'h00);
         wr_reg(8'h07 + 8'(ch), 8'h01);
         wr_reg(8'h0b, 8'(n));
         wr_reg(8'h06, m);
         cap[ch] <= 1'b1;
         repeat (6) @(posedge clk);
         cap[ch] <= 1'b0;
         rd_chk(8'h05, m);
         rd_chk(8'h0e + 8'(2 * ch), 8'(n));
         rd_chk(8'h04, 8'h00);
         wr_reg(8'h05, 8'h00);
         rd_chk(8'h05, 8'h00);
      end
      wr_reg(8'h08, 8'h00);
      wr_reg(8'h0f, 8'h00);
      wr_reg(8'h10, 8'h20);
      wr_reg(8'h06, 8'h01);
      wr_reg(8'h04, 8'h00);
      wr_reg(8'h00, 8'h01);
      repeat (40) @(posedge clk);
      irq_chk(5'h04);
      wr_reg(8'h03, 8'h00);
      irq_chk(5'h00);
      for (int p = 0; p < 2; p++) begin
         wr_reg(8'h02, 8'h10);
         wr_reg(8'h00, 8'h01 | 8'(p << 3));
         wr_reg(8'h02, 8'h17);
         wr_reg(8'h06, 8'h01);
         n = $urandom_range(8, 1);
         for (int k = 0; k < n; k++) begin
            pulse({1'b1, 1'(k)}, 4'($urandom_range(3, 1)));
         end
         chk("count", cnt, 16'(n));
      end
      wr_reg(8'h03, 8'h40);
      wr_reg(8'h02, 8'h10);
      wr_reg(8'h00, 8'h01);
      wr_reg(8'h04, 8'h00);
      wr_reg(8'h02, 8'h14);
      repeat (30) @(posedge clk);
      pulse(2'b10, 4'h5);
      #1;
      chk("count", cnt, 16'h0007);
      irq_chk(5'h10);
      wr_reg(8'h02, 8'h10);
      wr_reg(8'h02, 8'h94);
      pulse(2'b10, 4'h5);
      #1;
      chk("count delayed", cnt, 16'h0006);
      wr_reg(8'h02, 8'h10);
      wr_reg(8'h02, 8'h15);
      repeat (2) @(posedge clk);
      #1;
      c0 = cnt;
      pulse(2'b10, 4'ha);
      chk("count", cnt, c0 + 16'h000a);
      wr_reg(8'h02, 8'h10);
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h06, 8'h01);
      #1;
      chk("trigger out", {15'h0000, tout}, 16'h0001);
      wr_reg(8'h02, 8'h16);
      pulse(2'b10, 4'h1);
      rd_chk(8'h00, 8'h01);
      chk("count", 16'(cnt != 16'h0000), 16'h0001);
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h02, 8'h10);
      print_verdict();
   end
endmodule
`default_nettype wire
